// file: rtl/rfp_cfg.svh
// Purpose: Constants of the regulator fault protection block
// Assumes: 250 MHz system clock
// Notes:   Offsets, fields, resets and timing counts
`ifndef RFP_CFG_SVH
`define RFP_CFG_SVH

// ****************************************
// Widths and timing
// ****************************************
`define RFP_DAC_W        8
`define RFP_CNT_W        16
`define RFP_CLK_NS       4
`define RFP_SS_STEP_NS   1000
`define RFP_OV_STEP_NS   4000
`define RFP_OC_TIME_NS   50000
`define RFP_SS_CYC  ((`RFP_SS_STEP_NS + `RFP_CLK_NS - 1) / `RFP_CLK_NS)
`define RFP_OV_CYC  ((`RFP_OV_STEP_NS + `RFP_CLK_NS - 1) / `RFP_CLK_NS)
`define RFP_OC_CYC  ((`RFP_OC_TIME_NS + `RFP_CLK_NS - 1) / `RFP_CLK_NS)

// ****************************************
// Register map
// ****************************************
`define RFP_A_CTRL       8'h00
`define RFP_A_STATUS     8'h04
`define RFP_A_INT_STAT   8'h08
`define RFP_A_INT_MASK   8'h0C
`define RFP_A_DAC        8'h10
`define RFP_TARGET_RST   8'h80
`define RFP_MASK_RST     5'h00

// ****************************************
// Interrupt bit positions
// ****************************************
`define RFP_EV_SS_DONE   0
`define RFP_EV_OC_TRIP   1
`define RFP_EV_OV_TRIP   2
`define RFP_EV_UV        3
`define RFP_EV_LOCKOUT   4
`define RFP_EV_N         5

`endif

// file: rtl/rfp_pkg.sv
// Purpose: Types of the regulator fault protection block
// Assumes: rfp_cfg.svh supplies widths
// Notes:   Types only
`include "rfp_cfg.svh"
package rfp_pkg;

   typedef enum logic [2:0]
   {
      RFP_OFF  = 3'b000,
      RFP_RAMP = 3'b001,
      RFP_RUN  = 3'b011,
      RFP_OV   = 3'b010,
      RFP_OC   = 3'b110
   } rfp_state_t;

   typedef struct packed
   {
      logic en;
      logic vcc_ok;
      logic drv_ok;
      logic boot_ok;
      logic oc_lim;
      logic oc_heavy;
      logic uv;
      logic ov;
      logic ov_start;
      logic out_low;
      logic pwm;
      logic ready_in;
   } rfp_pins_t;

   typedef struct packed
   {
      rfp_state_t                st;
      logic [`RFP_DAC_W-1:0]     dac;
      logic [`RFP_DAC_W-1:0]     target;
      logic [`RFP_CNT_W-1:0]     oc_tmr;
      logic [`RFP_CNT_W-1:0]     step;
      logic [`RFP_EV_N-1:0]      ist;
      logic [`RFP_EV_N-1:0]      imask;
      logic [31:0]               rdata;
      logic                      uv_seen;
      logic                      hs;
      logic                      ls;
      logic                      rdy_o;
      logic                      rdy_oe;
      logic                      irq;
   } rfp_regs_t;

endpackage : rfp_pkg

// file: rtl/rfp_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to CLK_SYS
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/10ps
module rfp_sync3
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] agree;

   // First stage feeds only the second
   assign agree = ~(s2_q ^ s3_q);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q    <= '0;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q    <= (agree & s3_q) | (~agree & q);
      end
   end

endmodule : rfp_sync3

// file: rtl/rfp_top.sv
// Purpose: Start-up sequencing and fault protection of a buck regulator
// Assumes: Comparator results arrive asynchronously on pins
// Notes:   Analog thresholds live in the comparators, logic here only
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`include "rfp_cfg.svh"

// Functional notes
// - Soft-start steps DAC from zero upward
// - Current limit beyond 50 us shuts down
// - Heavy overload shuts down at once
// - Overcurrent latch holds until enable or supply
// - Undervoltage drops the ready flag
// - Overvoltage drops ready, ramps DAC down
// - Overvoltage: high side off, low side on until output is low
// - Overvoltage latch holds until enable or supply
// - Fixed overvoltage threshold during start-up
// - PWM comparator output drives gates
// - Supply lockout, driver and bootstrap lockout
module rfp_top
   import rfp_pkg::*;
#(
   parameter int DAC_W  = `RFP_DAC_W,
   parameter int SS_CYC = `RFP_SS_CYC,
   parameter int OV_CYC = `RFP_OV_CYC,
   parameter int OC_CYC = `RFP_OC_CYC
)
(
   input  wire logic             CLK_SYS,
   input  wire logic             RESETN,
   input  wire logic             EN,
   input  wire logic             VCC_OK,
   input  wire logic             DRV_VCC_OK,
   input  wire logic             BOOTSTRAP_SUPPLY_OK,
   input  wire logic             LIMIT_THRESHOLD_CURRENT_EXCEEDED,
   input  wire logic             HEAVY_OVERLOAD,
   input  wire logic             UV_CMP,
   input  wire logic             OV_CMP,
   input  wire logic             OV_START_CMP,
   input  wire logic             OUT_LOW_CMP,
   input  wire logic             PWM_CMP,
   input  wire logic             REGULATOR_READY_FLAG_I,
   output      logic             REGULATOR_READY_FLAG_O,
   output      logic             REGULATOR_READY_FLAG_OE,
   output      logic             GATE_HS,
   output      logic             GATE_LS,
   output      logic [DAC_W-1:0] DAC_CODE,
   output      logic             IRQ,
   input  wire logic [7:0]       REG_ADDR,
   input  wire logic [31:0]      REG_WDATA,
   input  wire logic             REG_WR,
   input  wire logic             REG_RD,
   output      logic [31:0]      REG_RDATA
);

   localparam logic [`RFP_CNT_W-1:0] SS_LAST = `RFP_CNT_W'(SS_CYC - 1);
   localparam logic [`RFP_CNT_W-1:0] OV_LAST = `RFP_CNT_W'(OV_CYC - 1);
   localparam logic [`RFP_CNT_W-1:0] OC_LAST = `RFP_CNT_W'(OC_CYC - 1);

   rfp_pins_t            pin_raw;
   rfp_pins_t            p;
   rfp_regs_t            r_q;
   rfp_regs_t            r_d;
   logic [`RFP_EV_N-1:0] ev;
   logic [`RFP_EV_N-1:0] w1c;
   logic                 active;
   logic                 drv_ok;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   assign pin_raw = '{en: EN, vcc_ok: VCC_OK, drv_ok: DRV_VCC_OK,
                      boot_ok: BOOTSTRAP_SUPPLY_OK,
                      oc_lim: LIMIT_THRESHOLD_CURRENT_EXCEEDED,
                      oc_heavy: HEAVY_OVERLOAD, uv: UV_CMP, ov: OV_CMP,
                      ov_start: OV_START_CMP, out_low: OUT_LOW_CMP,
                      pwm: PWM_CMP, ready_in: REGULATOR_READY_FLAG_I};

   rfp_sync3 #(.W($bits(rfp_pins_t))) u_sync
   (
      .clk   (CLK_SYS),
      .rst_n (RESETN),
      .d     (pin_raw),
      .q     (p)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      r_d    = r_q;
      ev     = '0;
      w1c    = '0;
      active = 1'b0;
      drv_ok = p.drv_ok & p.boot_ok;
      if (!p.vcc_ok || !p.en)
      begin
         // Leaving OFF restarts DAC, timers and step from zero
         if (r_q.st != RFP_OFF && !p.vcc_ok)
            ev[`RFP_EV_LOCKOUT] = 1'b1;
         r_d.st      = RFP_OFF;
         r_d.dac     = '0;
         r_d.oc_tmr  = '0;
         r_d.step    = '0;
         r_d.uv_seen = 1'b0;
      end
      else
      begin
         unique case (r_q.st)
            RFP_OFF:
            begin
               r_d.st = RFP_RAMP;
            end
            RFP_RAMP, RFP_RUN:
            begin
               active = 1'b1;
               if (r_q.st == RFP_RAMP ? p.ov_start : p.ov)
               begin
                  r_d.st   = RFP_OV;
                  r_d.step = '0;
                  ev[`RFP_EV_OV_TRIP] = 1'b1;
               end
               else if (p.oc_heavy)
               begin
                  r_d.st = RFP_OC;
                  ev[`RFP_EV_OC_TRIP] = 1'b1;
               end
               else if (p.oc_lim && r_q.oc_tmr == OC_LAST)
               begin
                  r_d.st = RFP_OC;
                  ev[`RFP_EV_OC_TRIP] = 1'b1;
               end
               else
               begin
                  r_d.oc_tmr = p.oc_lim ? r_q.oc_tmr + 1'b1 : '0;
                  // Fixed-rate stepping, also follows target changes
                  if (r_q.step == SS_LAST)
                  begin
                     r_d.step = '0;
                     if (r_q.dac < r_q.target)
                        r_d.dac = r_q.dac + 1'b1;
                     else if (r_q.dac > r_q.target)
                        r_d.dac = r_q.dac - 1'b1;
                     else if (r_q.st == RFP_RAMP)
                     begin
                        r_d.st = RFP_RUN;
                        ev[`RFP_EV_SS_DONE] = 1'b1;
                     end
                  end
                  else
                     r_d.step = r_q.step + 1'b1;
               end
            end
            RFP_OV:
            begin
               // Slow ramp-down, held until enable or supply drops
               if (r_q.step == OV_LAST)
               begin
                  r_d.step = '0;
                  if (r_q.dac != '0)
                     r_d.dac = r_q.dac - 1'b1;
               end
               else
                  r_d.step = r_q.step + 1'b1;
            end
            RFP_OC:
            begin
               r_d.st = RFP_OC;
            end
            default:
            begin
               r_d.st = RFP_OFF;
            end
         endcase
      end

      // Undervoltage only counts once regulating
      r_d.uv_seen = r_q.st == RFP_RUN && p.uv;
      if (r_d.uv_seen && !r_q.uv_seen)
         ev[`RFP_EV_UV] = 1'b1;

      // Driver lockout overrides every gate command
      r_d.hs = drv_ok && active && r_d.st == r_q.st && p.pwm;
      r_d.ls = drv_ok && ((active && r_d.st == r_q.st && !p.pwm)
               || (r_d.st == RFP_OV && !p.out_low));

      r_d.rdy_o  = 1'b0;
      r_d.rdy_oe = !(r_d.st == RFP_RUN && !p.uv);

      // ****************************************
      // Register port
      // ****************************************
      if (REG_WR)
      begin
         unique case (REG_ADDR)
            `RFP_A_CTRL:     r_d.target = REG_WDATA[DAC_W-1:0];
            `RFP_A_INT_STAT: w1c        = REG_WDATA[`RFP_EV_N-1:0];
            `RFP_A_INT_MASK: r_d.imask  = REG_WDATA[`RFP_EV_N-1:0];
            default:         r_d.target = r_q.target;
         endcase
      end
      // Set wins over a clear in the same cycle
      r_d.ist = (r_q.ist & ~w1c) | ev;
      r_d.irq = |(r_d.ist & r_d.imask);

      r_d.rdata = '0;
      if (REG_RD)
      begin
         unique case (REG_ADDR)
            `RFP_A_CTRL:     r_d.rdata = 32'(r_q.target);
            `RFP_A_STATUS:   r_d.rdata = {22'h00_0000, p.ready_in, p.en,
                                          p.vcc_ok, drv_ok, r_q.hs,
                                          r_q.ls, !r_q.rdy_oe, 3'(r_q.st)};
            `RFP_A_INT_STAT: r_d.rdata = 32'(r_q.ist);
            `RFP_A_INT_MASK: r_d.rdata = 32'(r_q.imask);
            `RFP_A_DAC:      r_d.rdata = 32'(r_q.dac);
            default:         r_d.rdata = '0;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         r_q        <= '0;
         r_q.st     <= RFP_OFF;
         r_q.target <= `RFP_TARGET_RST;
         r_q.imask  <= `RFP_MASK_RST;
         r_q.rdy_oe <= 1'b1;
      end
      else
         r_q <= r_d;
   end

   assign REGULATOR_READY_FLAG_O  = r_q.rdy_o;
   assign REGULATOR_READY_FLAG_OE = r_q.rdy_oe;
   assign GATE_HS                 = r_q.hs;
   assign GATE_LS                 = r_q.ls;
   assign DAC_CODE                = r_q.dac;
   assign IRQ                     = r_q.irq;
   assign REG_RDATA               = r_q.rdata;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   a_ramp_single_step: assert property (
      r_q.st == RFP_RAMP && r_d.st == RFP_RAMP |=>
         r_q.dac <= $past(r_q.dac) + 1'b1)
      else $error("DAC moved more than one step");
   a_oc_delay_trip: assert property (
      p.en && p.vcc_ok && r_q.st == RFP_RUN && !p.ov && p.oc_lim
      && r_q.oc_tmr == OC_LAST |=> r_q.st == RFP_OC)
      else $error("Current limit timer did not trip");
   a_oc_no_early: assert property (
      r_q.st == RFP_RUN && r_q.oc_tmr < OC_LAST - 1 && !p.oc_heavy
      && !p.ov |=> r_q.st != RFP_OC)
      else $error("Overcurrent trip before delay");
   a_heavy_trip_now: assert property (
      p.en && p.vcc_ok && r_q.st == RFP_RUN && p.oc_heavy && !p.ov
      |=> r_q.st == RFP_OC ##1 !GATE_HS && !GATE_LS)
      else $error("Heavy overload not shut down at once");
   a_oc_latch_hold: assert property (
      r_q.st == RFP_OC && p.en && p.vcc_ok |=> r_q.st == RFP_OC)
      else $error("Overcurrent latch released");
   a_uv_ready_low: assert property (
      p.uv |=> REGULATOR_READY_FLAG_OE)
      else $error("Ready stayed high under undervoltage");
   a_ov_entry_run: assert property (
      p.en && p.vcc_ok && r_q.st == RFP_RUN && p.ov
      |=> r_q.st == RFP_OV && REGULATOR_READY_FLAG_OE)
      else $error("Overvoltage not entered");
   a_ov_gate_force: assert property (
      r_q.st == RFP_OV && r_d.st == RFP_OV && drv_ok && !p.out_low
      |=> !GATE_HS && GATE_LS)
      else $error("Overvoltage gate override wrong");
   a_ov_latch_hold: assert property (
      r_q.st == RFP_OV && p.en && p.vcc_ok |=> r_q.st == RFP_OV)
      else $error("Overvoltage latch released");
   a_start_fixed_ov: assert property (
      r_q.st == RFP_RAMP && p.ov && !p.ov_start |=> r_q.st != RFP_OV)
      else $error("Start-up used relative threshold");
   a_pwm_to_gate: assert property (
      r_q.st == RFP_RUN && r_d.st == RFP_RUN && drv_ok
      |=> GATE_HS == $past(p.pwm) && GATE_LS == !$past(p.pwm))
      else $error("Gate does not follow PWM");
   a_driver_lockout: assert property (
      !drv_ok |=> !GATE_HS && !GATE_LS)
      else $error("Gate driven in lockout");
   a_reenable_clear: assert property (
      !p.en |=> r_q.st == RFP_OFF && DAC_CODE == '0 ##1 r_q.oc_tmr == '0)
      else $error("Disable did not clear state");

   c_ramp_done: cover property (r_q.st == RFP_RAMP ##1 r_q.st == RFP_RUN);
   c_oc_trip:   cover property (r_q.st == RFP_RUN ##1 r_q.st == RFP_OC);
   c_ov_trip:   cover property (r_q.st == RFP_RUN ##1 r_q.st == RFP_OV);
   c_irq_seen:  cover property (IRQ);

endmodule : rfp_top

// file: testbench/rfp_stage_model.sv
// Purpose: Power stage and ready pin as seen from the block's outputs
// Assumes: Gates active high, ready pin open drain with a pull-up
// Notes:   Output node drains only while the low side alone is on
`timescale 1ns/10ps
module rfp_stage_model
(
   input  wire logic clk,
   input  wire logic gate_hs,
   input  wire logic gate_ls,
   input  wire logic rdy_o,
   input  wire logic rdy_oe,
   output      logic rdy_pin,
   output      logic out_low,
   output      logic shoot
);
   int out_v = 6;

   // Released pin floats up to the pull-up level
   assign rdy_pin = rdy_oe ? rdy_o : 1'b1;
   assign out_low = (out_v == 0);

   initial shoot = 1'b0;

   always @(posedge clk)
   begin
      // Both switches on would short the input supply
      if (gate_hs && gate_ls)
         shoot <= 1'b1;
      if (gate_hs)
         out_v <= 6;
      else if (gate_ls && out_v > 0)
         out_v <= out_v - 1;
   end
endmodule : rfp_stage_model

// file: testbench/regulator_fault_protection_tb.sv
// Purpose: Self-checking bench of the fault protection block
// Assumes: Short counts, step 4, overvoltage step 8, trip 20 cycles
// Notes:   A pin change reaches the outputs five cycles later
`timescale 1ns/10ps
`include "rfp_cfg.svh"
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin \
   miscompares++; $display("MISMATCH %0t %s", $time, m); end end
module regulator_fault_protection_tb;
   import rfp_pkg::*;
   localparam int SS  = 4;
   localparam int OVC = 8;
   localparam int OC  = 20;
   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic        en    = 1'b0;
   logic        vok   = 1'b1;
   logic        dok   = 1'b1;
   logic        bok   = 1'b1;
   logic        lim   = 1'b0;
   logic        heavy = 1'b0;
   logic        uv    = 1'b0;
   logic        ov    = 1'b0;
   logic        ovs   = 1'b0;
   logic        pwm   = 1'b0;
   logic        wr    = 1'b0;
   logic        rd    = 1'b0;
   logic [7:0]  addr  = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [31:0] v;
   logic [7:0]  dac;
   logic [7:0]  last;
   logic        rdy_o, rdy_oe, rdy_pin, hs, ls, irq, out_low, shoot;
   logic        mon   = 1'b0;
   logic        first = 1'b1;
   int          miscompares = 0;
   int          checks_done = 0;
   int          tgt, e, step_p;
   int          gap = 0;
   int          expq[$];

   always #2 clk = ~clk;

   rfp_top #(.SS_CYC(SS), .OV_CYC(OVC), .OC_CYC(OC)) uut
   (
      .CLK_SYS(clk), .RESETN(rst_n), .EN(en), .VCC_OK(vok),
      .DRV_VCC_OK(dok), .BOOTSTRAP_SUPPLY_OK(bok),
      .LIMIT_THRESHOLD_CURRENT_EXCEEDED(lim), .HEAVY_OVERLOAD(heavy),
      .UV_CMP(uv), .OV_CMP(ov), .OV_START_CMP(ovs), .OUT_LOW_CMP(out_low),
      .PWM_CMP(pwm), .REGULATOR_READY_FLAG_I(rdy_pin),
      .REGULATOR_READY_FLAG_O(rdy_o), .REGULATOR_READY_FLAG_OE(rdy_oe),
      .GATE_HS(hs), .GATE_LS(ls), .DAC_CODE(dac), .IRQ(irq),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
      .REG_RDATA(rdata)
   );

   rfp_stage_model u_stage
   (
      .clk(clk), .gate_hs(hs), .gate_ls(ls), .rdy_o(rdy_o),
      .rdy_oe(rdy_oe), .rdy_pin(rdy_pin), .out_low(out_low), .shoot(shoot)
   );

   // ****
   // DAC model: each move is the next queued code, one period apart
   // ****
   always @(posedge clk)
   begin
      gap++;
      if (mon && dac !== last)
      begin
         e = expq.size() ? expq.pop_front() : -1;
         `CHK(dac, 8'(e), "dac code")
         if (!first)
            `CHK(gap, step_p, "dac period")
         first = 1'b0;
         gap = 0;
      end
      last = dac;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask : rd_reg

   task automatic chk_st(input rfp_state_t s);
      rd_reg(`RFP_A_STATUS);
      `CHK(v[2:0], s, "state")
   endtask : chk_st

   task automatic give_verdict;
      $display("Counts: %0d checks, %0d mismatches", checks_done,
               miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // Drop enable, then ramp again from zero to the target
   task automatic restart;
      en <= 1'b0;
      cyc(8);
      `CHK(dac, 8'h00, "dac cleared")
      chk_st(RFP_OFF);
      expq = {};
      for (int i = 1; i <= tgt; i++)
         expq.push_back(i);
      step_p = SS;
      first = 1'b1;
      mon = 1'b1;
      en <= 1'b1;
      wait_dac(tgt, tgt * SS + 30);
      cyc(3);
      mon = 1'b0;
      `CHK(expq.size(), 0, "ramp codes left")
      chk_st(RFP_RUN);
      `CHK({rdy_oe, rdy_pin}, 2'b01, "ready")
   endtask : restart

   task automatic wait_dac(input int val, input int lim_c);
      for (int i = 0; i < lim_c && dac !== 8'(val); i++)
         @(posedge clk);
      `CHK(dac, 8'(val), "dac end")
   endtask : wait_dac

   // ****
   // Main sequence
   // ****
   initial
   begin
      void'($urandom(32'h02d603b5));
      cyc(12);
      rst_n <= 1'b1;
      cyc(1);
      `CHK({rdy_oe, hs, ls, dac, irq}, 12'h800, "reset outputs")
      rd_reg(`RFP_A_CTRL);
      `CHK(v, 32'h0000_0080, "ctrl reset")
      rd_reg(`RFP_A_INT_MASK);
      `CHK(v, 32'h0000_0000, "mask reset")
      wr_reg(`RFP_A_DAC, 32'h0000_00ff);
      rd_reg(`RFP_A_DAC);
      `CHK(v, 32'h0000_0000, "dac read only")
      rd_reg(8'h3c);
      `CHK(v, 32'h0000_0000, "unmapped")
      $display("test reset done");
      tgt = 3 + $urandom % 6;
      wr_reg(`RFP_A_CTRL, 32'(tgt));
      restart();
      `CHK(irq, 1'b0, "masked irq")
      wr_reg(`RFP_A_INT_MASK, 32'h0000_001f);
      cyc(2);
      `CHK(irq, 1'b1, "irq raised")
      rd_reg(`RFP_A_INT_STAT);
      `CHK(v[4:0], 5'h01, "ramp event")
      wr_reg(`RFP_A_INT_STAT, 32'h0000_001f);
      cyc(2);
      `CHK(irq, 1'b0, "irq cleared")
      repeat (4)
      begin
         pwm <= 1'($urandom);
         cyc(7);
         `CHK({hs, ls}, {pwm, ~pwm}, "pwm gates")
      end
      uv <= 1'b1;
      cyc(7);
      `CHK({rdy_oe, rdy_pin}, 2'b10, "uv")
      uv <= 1'b0;
      cyc(7);
      `CHK(rdy_oe, 1'b0, "uv gone")
      rd_reg(`RFP_A_INT_STAT);
      `CHK(v[3], 1'b1, "uv event")
      wr_reg(`RFP_A_CTRL, 32'(tgt - 1));
      cyc(SS + 2);
      `CHK(dac, 8'(tgt - 1), "dac follows target")
      wr_reg(`RFP_A_CTRL, 32'(tgt));
      cyc(SS + 2);
      `CHK(dac, 8'(tgt), "dac back at target")
      $display("test ramp and run done");
      pwm <= 1'b1;
      lim <= 1'b1;
      cyc(OC - 6);
      lim <= 1'b0;
      cyc(8);
      lim <= 1'b1;
      cyc(OC);
      `CHK(hs, 1'b1, "no early trip")
      cyc(4);
      `CHK(hs, 1'b1, "trip not before limit")
      cyc(2);
      `CHK({hs, ls}, 2'b00, "timed trip")
      lim <= 1'b0;
      cyc(20);
      chk_st(RFP_OC);
      restart();
      wr_reg(`RFP_A_INT_STAT, 32'h0000_001f);
      heavy <= 1'b1;
      cyc(8);
      `CHK({hs, ls}, 2'b00, "heavy trip")
      heavy <= 1'b0;
      chk_st(RFP_OC);
      rd_reg(`RFP_A_INT_STAT);
      `CHK(v[1], 1'b1, "oc event")
      restart();
      $display("test overcurrent done");
      ov <= 1'b1;
      cyc(7);
      `CHK({hs, ls, rdy_oe}, 3'b011, "ov entry")
      ov <= 1'b0;
      expq = {};
      for (int i = tgt - 1; i >= 0; i--)
         expq.push_back(i);
      step_p = OVC;
      first = 1'b1;
      mon = 1'b1;
      wait_dac(0, tgt * OVC + 30);
      // Let the model see the last code before it stops
      cyc(1);
      mon = 1'b0;
      `CHK(expq.size(), 0, "ov codes left")
      `CHK({ls, out_low}, 2'b01, "ls off at floor")
      chk_st(RFP_OV);
      restart();
      wr_reg(`RFP_A_CTRL, 32'h0000_0028);
      en <= 1'b0;
      cyc(8);
      en <= 1'b1;
      cyc(12);
      ov <= 1'b1;
      cyc(8);
      chk_st(RFP_RAMP);
      ov <= 1'b0;
      ovs <= 1'b1;
      cyc(8);
      chk_st(RFP_OV);
      ovs <= 1'b0;
      wr_reg(`RFP_A_CTRL, 32'(tgt));
      restart();
      $display("test overvoltage done");
      for (int k = 0; k < 2; k++)
      begin
         {dok, bok} <= k ? 2'b10 : 2'b01;
         cyc(7);
         `CHK({hs, ls}, 2'b00, "driver lockout")
         chk_st(RFP_RUN);
         `CHK(v, 32'h0000_038b, "status word")
         {dok, bok} <= 2'b11;
         cyc(7);
      end
      vok <= 1'b0;
      cyc(7);
      chk_st(RFP_OFF);
      rd_reg(`RFP_A_INT_STAT);
      `CHK(v[4], 1'b1, "lockout event")
      `CHK(irq, 1'b1, "irq lockout")
      `CHK(shoot, 1'b0, "shoot through")
      $display("test lockout done");
      give_verdict();
   end

   initial
   begin
      #(4 * 20000);
      miscompares++;
      give_verdict();
   end
endmodule : regulator_fault_protection_tb
